// >>> verilog/legacy_steer_pkg.sv
// package: register map, field layout and decode constants for steering
package legacy_steer_pkg;

    // ------------------------------------------------------------------
    // register offsets and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] SHADOW_ATTR_MAP_SIX_OFS   = 8'h96;
    localparam logic [7:0] LEGACY_HOLE_VIDEO_CTL_OFS = 8'h97;
    localparam logic [7:0] SHADOW_ATTR_MAP_SIX_RST   = 8'h00;
    localparam logic [7:0] LEGACY_HOLE_VIDEO_CTL_RST = 8'h00;

    // ------------------------------------------------------------------
    // field positions and writable masks
    // ------------------------------------------------------------------
    localparam int UPPER_ATTR_LSB   = 4;
    localparam int LOWER_ATTR_LSB   = 0;
    localparam int GAP_ON_BIT       = 7;
    localparam int MONO_PRESENT_BIT = 0;
    localparam logic [7:0] ATTR_WR_MASK = 8'h33;
    localparam logic [7:0] CTL_WR_MASK  = 8'h81;

    // ------------------------------------------------------------------
    // address ranges
    // ------------------------------------------------------------------
    localparam logic [35:0] LOWER_QTR_BASE = 36'h0000E8000;
    localparam logic [35:0] LOWER_QTR_TOP  = 36'h0000EBFFF;
    localparam logic [35:0] UPPER_QTR_BASE = 36'h0000EC000;
    localparam logic [35:0] UPPER_QTR_TOP  = 36'h0000EFFFF;
    localparam logic [35:0] GAP_BASE       = 36'h000F00000;
    localparam logic [35:0] GAP_TOP        = 36'h000FFFFFF;
    localparam logic [35:0] MONO_MEM_BASE  = 36'h0000B0000;
    localparam logic [35:0] MONO_MEM_TOP   = 36'h0000B7FFF;
    localparam logic [35:0] VGA_MEM_BASE   = 36'h0000A0000;
    localparam logic [35:0] VGA_MEM_TOP    = 36'h0000BFFFF;
    localparam logic [9:0]  MONO_IO_BASE   = 10'h3B4;
    localparam logic [9:0]  MONO_IO_TOP    = 10'h3BF;
    localparam logic [9:0]  MONO_PORT_BASE = 10'h3BC;
    localparam logic [9:0]  VGA_IO_BASE    = 10'h3C0;
    localparam logic [9:0]  VGA_IO_TOP     = 10'h3DF;
    localparam logic [11:0] MONO_IO_HITS   = 12'h873;

    // ------------------------------------------------------------------
    // attribute codes and destinations
    // ------------------------------------------------------------------
    localparam logic [1:0] ATTR_OFF    = 2'h0;
    localparam logic [1:0] ATTR_RD_ONLY = 2'h1;
    localparam logic [1:0] ATTR_WR_ONLY = 2'h2;
    localparam logic [1:0] ATTR_NORMAL  = 2'h3;

    typedef enum logic [1:0] {
        DEST_NONE  = 2'h0,
        DEST_DRAM  = 2'h1,
        DEST_SOUTH = 2'h3,
        DEST_GFX   = 2'h2
    } dest_e;

    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic        is_write;
        logic [35:0] addr;
        logic [3:0]  byte_en;
    } cycle_s;

    typedef struct packed {
        logic        valid;
        logic [1:0]  dest;
    } route_s;

endpackage : legacy_steer_pkg

// >>> verilog/legacy_region_steering.sv
// module: legacy region address steering with its two config registers
//
// Functional notes
// - upper quarter steered by bits 5:4
// - lower quarter steered by bits 1:0
// - code 00 sends everything south
// - code 01 reads DRAM, writes south
// - code 10 writes DRAM, reads south
// - code 11 reads and writes DRAM
// - gap bit unclaims 15-16 MB, no relocation
// - mono bit combines with bridge VGA enable
// - VGA off sends mono I/O south
// - VGA on, no mono: 3BC-3BF by window
// - mono memory and I/O locations defined
// - mono I/O decode ignores A[15:10]
// - with mono on, any touched mono byte goes south
// - both off routes video south
// - VGA on, no mono: all to graphics except 3BC-3BF outside window
// - both on: VGA graphics, mono south
`timescale 1ns/10ps
module legacy_region_steering
    import legacy_steer_pkg::*;
(
    input  wire logic       clock,         // core clock
    input  wire logic       rst_n,         // sync reset, active low
    input  wire logic       cfg_wr,        // config write strobe
    input  wire logic       cfg_rd,        // config read strobe
    input  wire logic [7:0] cfg_addr,      // config offset
    input  wire logic [7:0] cfg_wdata,     // config write data
    input  wire logic       cfg_lock,      // platform lock condition
    output logic      [7:0] cfg_rdata,     // config read data
    output logic            cfg_rvalid,    // read data valid pulse
    input  wire logic       legacy_video_route_on, // bridge VGA enable
    input  wire logic       gfx_io_win_hit, // address in graphics I/O window
    input  wire cycle_s     cyc_in,        // processor cycle
    output route_s          route_out,     // steering decision
    output logic            upper_quarter_rd_dram, // status view
    output logic            fifteen_meg_gap_active // status view
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [7:0] attr_q;
    logic [7:0] attr_d;
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rvalid_q;
    route_s     route_q;
    route_s     route_d;
    logic       up_rd_q;
    logic       gap_q;

    // ------------------------------------------------------------------
    // offset decode and write path
    // ------------------------------------------------------------------
    wire sel_attr = cfg_addr == SHADOW_ATTR_MAP_SIX_OFS;
    wire sel_ctl  = cfg_addr == LEGACY_HOLE_VIDEO_CTL_OFS;

    // the lock freezes both registers whatever the offset
    wire wr_ok    = cfg_wr & ~cfg_lock;
    wire wr_attr  = wr_ok & sel_attr;
    wire wr_ctl   = wr_ok & sel_ctl;

    // reserved bits are dropped on the way in and so read as zero
    wire [7:0] attr_wval = cfg_wdata & ATTR_WR_MASK;
    wire [7:0] ctl_wval  = cfg_wdata & CTL_WR_MASK;

    assign attr_d = wr_attr ? attr_wval : attr_q;
    assign ctl_d  = wr_ctl  ? ctl_wval  : ctl_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            attr_q <= SHADOW_ATTR_MAP_SIX_RST;
            ctl_q  <= LEGACY_HOLE_VIDEO_CTL_RST;
        end else begin
            attr_q <= attr_d;
            ctl_q  <= ctl_d;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // unmapped offsets return zero; data holds until the next read
    wire [7:0] rd_attr = sel_attr ? attr_q : 8'h00;
    wire [7:0] rd_ctl  = sel_ctl  ? ctl_q  : 8'h00;
    assign rdata_d = cfg_rd ? (rd_attr | rd_ctl) : rdata_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= cfg_rd;
        end
    end

    // ------------------------------------------------------------------
    // field views
    // ------------------------------------------------------------------
    wire [1:0] upper_quarter_attr = attr_q[UPPER_ATTR_LSB +: 2];
    wire [1:0] lower_quarter_attr = attr_q[LOWER_ATTR_LSB +: 2];
    wire fifteen_meg_gap_on   = ctl_q[GAP_ON_BIT];
    wire mono_adapter_present = ctl_q[MONO_PRESENT_BIT];

    // ------------------------------------------------------------------
    // cycle qualifiers
    // ------------------------------------------------------------------
    wire [35:0] a       = cyc_in.addr;
    wire        mem_cyc = cyc_in.valid & ~cyc_in.is_io;
    wire        io_cyc  = cyc_in.valid & cyc_in.is_io;
    wire        wr_cyc  = cyc_in.is_write;

    // ------------------------------------------------------------------
    // shadow quarters
    // ------------------------------------------------------------------
    // entry 0 is the lower quarter, entry 1 the upper quarter
    wire [1:0][35:0] qtr_base = {UPPER_QTR_BASE, LOWER_QTR_BASE};
    wire [1:0][35:0] qtr_top  = {UPPER_QTR_TOP, LOWER_QTR_TOP};
    wire [1:0][1:0]  qtr_code = {upper_quarter_attr, lower_quarter_attr};
    logic [1:0] qtr_hit;
    logic [1:0] qtr_dram;

    genvar q;
    generate
        for (q = 0; q < 2; q++) begin : g_qtr
            wire c_off   = qtr_code[q] == ATTR_OFF;
            wire c_rd    = qtr_code[q] == ATTR_RD_ONLY;
            wire c_wr    = qtr_code[q] == ATTR_WR_ONLY;
            wire c_norm  = qtr_code[q] == ATTR_NORMAL;
            wire rd_dram = c_rd | c_norm;
            wire wr_dram = c_wr | c_norm;
            assign qtr_hit[q]  = mem_cyc & (a >= qtr_base[q]) &
                                 (a <= qtr_top[q]);
            assign qtr_dram[q] = ~c_off & (wr_cyc ? wr_dram : rd_dram);
        end
    endgenerate

    wire in_lower       = qtr_hit[0];
    wire in_upper       = qtr_hit[1];
    wire in_shadow      = in_lower | in_upper;
    wire shadow_to_dram = in_upper ? qtr_dram[1] : qtr_dram[0];

    // ------------------------------------------------------------------
    // fifteen meg gap
    // ------------------------------------------------------------------
    // the DRAM behind the gap is simply lost, nothing is relocated
    wire gap_rng = (a >= GAP_BASE) & (a <= GAP_TOP);
    wire in_gap  = mem_cyc & fifteen_meg_gap_on & gap_rng;

    // ------------------------------------------------------------------
    // video memory decode
    // ------------------------------------------------------------------
    wire in_mono_mem = mem_cyc & (a >= MONO_MEM_BASE) &
                       (a <= MONO_MEM_TOP);
    wire in_vga_mem  = mem_cyc & (a >= VGA_MEM_BASE) &
                       (a <= VGA_MEM_TOP) & ~in_mono_mem;

    // ------------------------------------------------------------------
    // video I/O lanes
    // ------------------------------------------------------------------
    wire [9:0] io_a = {a[9:2], 2'h0};

    // per byte lane: does this byte hit a listed mono location
    logic [3:0] lane_mono;
    logic [3:0] lane_port;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            wire [9:0] ba = io_a | 10'(g);
            wire in_rng   = (ba >= MONO_IO_BASE) & (ba <= MONO_IO_TOP);
            wire [3:0] ix = 4'(ba - MONO_IO_BASE);
            assign lane_mono[g] = cyc_in.byte_en[g] & in_rng &
                                  MONO_IO_HITS[ix];
            assign lane_port[g] = cyc_in.byte_en[g] &
                                  (ba >= MONO_PORT_BASE) &
                                  (ba <= MONO_IO_TOP);
        end
    endgenerate

    wire io_mono  = io_cyc & (|lane_mono);
    wire io_port  = io_cyc & (|lane_port);
    wire io_vga   = io_cyc & (io_a >= VGA_IO_BASE) & (io_a <= VGA_IO_TOP);
    wire io_monor = io_cyc & (io_a >= MONO_IO_BASE) &
                    (io_a <= MONO_IO_TOP);

    // ------------------------------------------------------------------
    // routing classes, highest priority first
    // ------------------------------------------------------------------
    wire vga_on  = legacy_video_route_on;
    // mono set without VGA is the illegal pair and counts as absent
    wire mono_on = mono_adapter_present & vga_on;

    wire is_mono  = in_mono_mem | io_mono | io_monor;
    wire is_vga   = in_vga_mem | io_vga;
    wire cls_shad = in_shadow;
    wire cls_gap  = ~cls_shad & in_gap;
    wire cls_mono = ~cls_shad & ~cls_gap & is_mono;
    wire cls_vga  = ~cls_shad & ~cls_gap & ~is_mono & is_vga;
    wire cls_io   = ~cls_shad & ~is_mono & ~is_vga & io_cyc;
    wire cls_dram = mem_cyc & ~cls_shad & ~cls_gap & ~is_mono & ~is_vga;

    // ------------------------------------------------------------------
    // per-class destination
    // ------------------------------------------------------------------
    wire shad_south = cls_shad & ~shadow_to_dram;
    wire shad_dram  = cls_shad & shadow_to_dram;

    wire mono_vga_off = cls_mono & ~vga_on;
    wire mono_claimed = cls_mono & mono_on;
    wire mono_no_win  = cls_mono & vga_on & ~mono_on &
                        io_port & ~gfx_io_win_hit;
    wire mono_south   = mono_vga_off | mono_claimed | mono_no_win;
    wire mono_gfx     = cls_mono & ~mono_south;

    wire vga_south = cls_vga & ~vga_on;
    wire vga_gfx   = cls_vga & vga_on;

    // ------------------------------------------------------------------
    // destination encode
    // ------------------------------------------------------------------
    wire to_south = shad_south | mono_south | vga_south |
                    cls_gap | cls_io;
    wire to_gfx   = mono_gfx | vga_gfx;
    wire to_dram  = shad_dram | cls_dram;

    wire [1:0] dest_code = to_south ? DEST_SOUTH :
                           to_gfx   ? DEST_GFX   :
                           to_dram  ? DEST_DRAM  : DEST_NONE;

    assign route_d = '{valid: cyc_in.valid, dest: dest_code};

    // ------------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            route_q <= '0;
        end else begin
            route_q <= route_d;
        end
    end

    // status views follow the register bits one cycle late
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            up_rd_q <= 1'b0;
            gap_q   <= 1'b0;
        end else begin
            up_rd_q <= upper_quarter_attr[0];
            gap_q   <= fifteen_meg_gap_on;
        end
    end

    assign cfg_rdata              = rdata_q;
    assign cfg_rvalid             = rvalid_q;
    assign route_out              = route_q;
    assign upper_quarter_rd_dram  = up_rd_q;
    assign fifteen_meg_gap_active = gap_q;

endmodule : legacy_region_steering

// >>> verif/legacy_steer_chk.sv
// checker: steering and config timing relations at the block ports
`timescale 1ns/10ps
module legacy_steer_chk
    import legacy_steer_pkg::*;
(
    input wire logic       clock,                  // clk
    input wire logic       rst_n,                  // reset
    input wire logic       cfg_wr,                 // wr strobe
    input wire logic       cfg_rd,                 // rd strobe
    input wire logic [7:0] cfg_addr,               // offset
    input wire logic       cfg_lock,               // lock
    input wire logic [7:0] cfg_rdata,              // rd data
    input wire logic       cfg_rvalid,             // rd valid
    input wire logic       legacy_video_route_on,  // vga on
    input wire cycle_s     cyc_in,                 // cycle
    input wire route_s     route_out,              // decision
    input wire logic       upper_quarter_rd_dram,  // status
    input wire logic       fifteen_meg_gap_active  // status
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    wire [35:0] a = cyc_in.addr;
    wire mem = cyc_in.valid & ~cyc_in.is_io;
    wire rd  = ~cyc_in.is_write;
    wire up  = mem & a >= UPPER_QTR_BASE & a <= UPPER_QTR_TOP;
    wire gap = mem & a >= GAP_BASE & a <= GAP_TOP;
    wire vm  = mem & a >= VGA_MEM_BASE & a <= VGA_MEM_TOP;
    wire vio = cyc_in.valid & cyc_in.is_io & |cyc_in.byte_en
               & a[9:0] >= VGA_IO_BASE & a[9:0] <= VGA_IO_TOP;
    chk_upper_dram: assert property (
        up & rd & upper_quarter_rd_dram |=> route_out.dest == DEST_DRAM)
        else $error("upper read not sent to dram");
    chk_upper_south: assert property (
        up & rd & !upper_quarter_rd_dram |=> route_out.dest == DEST_SOUTH)
        else $error("upper read not sent south");
    chk_gap_on: assert property (
        gap & fifteen_meg_gap_active |=> route_out.dest != DEST_DRAM)
        else $error("gap address claimed for dram");
    chk_gap_off: assert property (
        gap & !fifteen_meg_gap_active |=> route_out.dest == DEST_DRAM)
        else $error("gap off but not dram");
    chk_video_south: assert property (
        vm & !legacy_video_route_on |=> route_out.dest == DEST_SOUTH)
        else $error("video memory not south");
    chk_vga_io_gfx: assert property (
        vio & legacy_video_route_on |=> route_out.dest == DEST_GFX)
        else $error("vga io not sent to graphics");
    chk_rsv_zero: assert property (
        cfg_rd & cfg_addr == SHADOW_ATTR_MAP_SIX_OFS
        |=> cfg_rvalid & (cfg_rdata & ~ATTR_WR_MASK) == 8'h00)
        else $error("reserved attr bits not zero");
    chk_lock_hold: assert property (
        cfg_wr & cfg_lock & cfg_addr == LEGACY_HOLE_VIDEO_CTL_OFS |=> ##1
        fifteen_meg_gap_active == $past(fifteen_meg_gap_active, 2))
        else $error("locked write changed gap bit");
endmodule : legacy_steer_chk

// >>> verif/cpu_host_model.sv
// partner: processor host bus issuing one cycle per request
`timescale 1ns/10ps
module cpu_host_model
    import legacy_steer_pkg::*;
(
    input  wire logic clock, // core clock
    output cycle_s    cyc    // cycle to steer
);
    initial cyc = '0;
    // idle fields flip so stale values never look valid
    task automatic issue(input logic io, wr, input logic [35:0] a,
                         input logic [3:0] be);
        @(posedge clock);
        cyc <= '{1'b1, io, wr, a, be};
        @(posedge clock);
        cyc <= '{1'b0, ~io, ~wr, ~a, ~be};
    endtask : issue
endmodule : cpu_host_model

// >>> verif/legacy_region_steering_tb_top.sv
// testbench: register access, shadow quarters, gap and video routing
`timescale 1ns/10ps
bind legacy_region_steering legacy_steer_chk i_chk(.*);
module legacy_region_steering_tb_top
    import legacy_steer_pkg::*;
;
    logic clock = 0, rst_n = 0, cfg_wr = 0, cfg_rd = 0, cfg_lock = 0;
    logic vga = 0, win = 0, rvalid, gap_st, uq_st;
    logic [7:0] cfg_addr = 0, cfg_wdata = 0, rdata;
    cycle_s cyc;
    route_s rt;
    int errors = 0, n_tests = 0;
    always #2.5 clock = ~clock;
    cpu_host_model i_cpu(.clock(clock), .cyc(cyc));
    legacy_region_steering i_dut(.clock(clock), .rst_n(rst_n),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_lock(cfg_lock), .cfg_rdata(rdata),
        .cfg_rvalid(rvalid), .legacy_video_route_on(vga),
        .gfx_io_win_hit(win), .cyc_in(cyc), .route_out(rt),
        .upper_quarter_rd_dram(uq_st), .fifteen_meg_gap_active(gap_st));
    task automatic check(input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, d);
        @(posedge clock);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clock);
        cfg_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, exp);
        @(posedge clock);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clock);
        cfg_rd <= 1'b0;
        @(negedge clock);
        check({7'h00, rvalid}, 8'h01);
        check(rdata, exp);
    endtask : rdc
    task automatic go(input logic io, w, input logic [35:0] a,
                      input logic [3:0] be, input dest_e exp);
        i_cpu.issue(io, w, a, be);
        @(negedge clock);
        check({5'h00, rt}, {5'h00, 1'b1, exp});
    endtask : go
    function automatic dest_e dst(input logic [1:0] c, input logic w);
        case (c)
            ATTR_OFF:     return DEST_SOUTH;
            ATTR_RD_ONLY: return w ? DEST_SOUTH : DEST_DRAM;
            ATTR_WR_ONLY: return w ? DEST_DRAM : DEST_SOUTH;
            default:      return DEST_DRAM;
        endcase
    endfunction : dst
    task automatic t_regs();
        rdc(SHADOW_ATTR_MAP_SIX_OFS, SHADOW_ATTR_MAP_SIX_RST);
        rdc(LEGACY_HOLE_VIDEO_CTL_OFS, LEGACY_HOLE_VIDEO_CTL_RST);
        wr(SHADOW_ATTR_MAP_SIX_OFS, 8'hFF);
        rdc(SHADOW_ATTR_MAP_SIX_OFS, 8'h33);
        wr(LEGACY_HOLE_VIDEO_CTL_OFS, 8'hFE);
        rdc(LEGACY_HOLE_VIDEO_CTL_OFS, 8'h80);
        wr(8'h98, 8'hFF);
        rdc(8'h98, 8'h00);
        @(posedge clock);
        cfg_lock <= 1'b1;
        wr(LEGACY_HOLE_VIDEO_CTL_OFS, 8'h00);
        rdc(LEGACY_HOLE_VIDEO_CTL_OFS, 8'h80);
        @(posedge clock);
        cfg_lock <= 1'b0;
    endtask : t_regs
    task automatic t_attr();
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr(SHADOW_ATTR_MAP_SIX_OFS, {2'h0, c, 2'h0, ~c});
            for (int w = 0; w < 2; w++) begin
                go(0, w[0], 36'hEC000, 4'hF, dst(c, w[0]));
                go(0, w[0], 36'hEFFFF, 4'hF, dst(c, w[0]));
                go(0, w[0], 36'hE8000, 4'hF, dst(~c, w[0]));
                go(0, w[0], 36'hEBFFF, 4'hF, dst(~c, w[0]));
            end
            check({7'h00, uq_st}, {7'h00, c[0]});
        end
    endtask : t_attr
    task automatic t_gap();
        wr(LEGACY_HOLE_VIDEO_CTL_OFS, 8'h80);
        go(0, 0, 36'hF00000, 4'hF, DEST_SOUTH);
        go(0, 1, 36'hFFFFFF, 4'hF, DEST_SOUTH);
        go(0, 0, 36'hEFFFFF, 4'hF, DEST_DRAM);
        check({7'h00, gap_st}, 8'h01);
        wr(LEGACY_HOLE_VIDEO_CTL_OFS, 8'h00);
        go(0, 0, 36'hF00000, 4'hF, DEST_DRAM);
        check({7'h00, gap_st}, 8'h00);
    endtask : t_gap
    task automatic vid(input logic v, m);
        @(posedge clock);
        vga <= v;
        wr(LEGACY_HOLE_VIDEO_CTL_OFS, {7'h00, m});
    endtask : vid
    task automatic t_video();
        vid(0, 0);
        go(0, 0, 36'hB0000, 4'hF, DEST_SOUTH);
        go(0, 1, 36'hA0000, 4'hF, DEST_SOUTH);
        go(1, 0, 36'hFFBC, 4'h8, DEST_SOUTH);
        vid(1, 0);
        go(0, 0, 36'hB7FFF, 4'hF, DEST_GFX);
        go(1, 1, 36'h3B4, 4'h1, DEST_GFX);
        go(1, 0, 36'h3BC, 4'h1, DEST_SOUTH);
        @(posedge clock);
        win <= 1'b1;
        go(1, 0, 36'h3BC, 4'h1, DEST_GFX);
        vid(1, 1);
        go(0, 0, 36'hB0000, 4'hF, DEST_SOUTH);
        go(0, 1, 36'hB8000, 4'hF, DEST_GFX);
        go(1, 0, 36'hFFB4, 4'h1, DEST_SOUTH);
        go(1, 1, 36'h3B8, 4'hF, DEST_SOUTH);
        go(1, 0, 36'h3BC, 4'h8, DEST_SOUTH);
        go(1, 0, 36'hFFC0, 4'h1, DEST_GFX);
    endtask : t_video
    task automatic close_out();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        t_regs();
        t_attr();
        t_gap();
        t_video();
        close_out();
    end
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        close_out();
    end
endmodule : legacy_region_steering_tb_top
